// ==== dsadc_ctrl.sv ====
// Delta-sigma converter control with Avalon-MM register slave
// Notes on behaviour
// - Repeatedly convert selected pair, interrupt each end
// - Lower resolution gives shorter conversion
// - Move result to wide register, then interrupt
// - Wide register holds value in upper bits
// - High-byte register holds top eight bits
// - Result register reads insert a wait cycle
// - Unselected pins stay usable as port pins
// - Status tells which channel completed
// - Pin select register picks analog or digital
// - Pin direction register sets input or output
// - Any first control write reinitializes conversion
// - Sample-count code selects 256 up to 65536
`default_nettype none
module dsadc_ctrl (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // Avalon-MM slave
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Analog core
   input  wire logic        mod_bit,
   output logic             core_power,
   output logic [1:0]       core_pair,
   // Shared port pins
   input  wire logic [7:0]  pin_in,
   output logic [7:0]       pin_out,
   output logic [7:0]       pin_oe,
   // Interrupt
   output logic             conv_done_irq
);
   typedef struct packed {
      logic [7:0]  ctl0;
      logic [7:0]  ctl1;
      logic [31:0] wide;
      logic [7:0]  high;
      logic [1:0]  status;
      logic [15:0] pinsel;
      logic [7:0]  pindir;
      logic [7:0]  portout;
      logic        irq_st;
      logic        irq_msk;
      logic        reinit;
      logic        rd_wait;
      logic        wait_q;
      logic [31:0] rdata;
      logic        irq;
      logic [7:0]  out;
      logic [7:0]  oe;
      logic [7:0]  s1;
      logic [7:0]  s2;
      logic [7:0]  s3;
      logic [7:0]  pins;
      logic [1:0]  pair_act;
      logic [16:0] gap;
   } st_t;
   st_t st_reg, st_next;

   logic        done;
   logic [15:0] value;

   // Sample counter restarts on any first control write and halts while stopped
   dsadc_modulator u_mod (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .clear   (st_reg.reinit),
      .run     (st_reg.ctl0[dsadc_pkg::PON_BIT] && st_reg.ctl0[dsadc_pkg::RUN_BIT]),
      .nsel    (st_reg.ctl1[dsadc_pkg::NSEL_LSB +: 3]),
      .bit_in  (mod_bit),
      .done    (done),
      .value   (value)
   );

   function automatic logic is_result(input logic [3:0] a);
      is_result = (a == dsadc_pkg::WIDE_OFS) || (a == dsadc_pkg::HIGH_OFS);
   endfunction

   // Samples per conversion for a count code, kept apart from the modulator's own copy
   function automatic logic [16:0] samples_of(input logic [2:0] code);
      samples_of = (code == 3'h0) ? dsadc_pkg::N_MIN
                 : 17'(dsadc_pkg::N_BASE << (code - 3'h1));
   endfunction

   always_comb begin
      logic [3:0] a;
      logic       wr_go;
      logic       rd_go;
      logic       busy;
      logic       stall;
      logic       run_on;
      a = address[5:2];
      run_on = st_reg.ctl0[dsadc_pkg::PON_BIT] && st_reg.ctl0[dsadc_pkg::RUN_BIT];
      // Every transfer waits one cycle, so read data and waitrequest can both be flops
      busy = (read || write) && st_reg.wait_q;
      // Result reads wait one cycle more before their data is loaded
      stall = read && is_result(a) && !st_reg.rd_wait;
      rd_go = read && busy && !stall;
      // A write lands only at the edge at which waitrequest is seen low
      wr_go = write && !st_reg.wait_q;
      st_next = st_reg;
      st_next.reinit = 1'b0;
      st_next.wait_q = !(busy && !stall);
      st_next.rd_wait = stall && st_reg.wait_q;
      // Conversion end: load result, note channel, then raise flag
      if (done) begin
         st_next.wide   = {value, 16'h0000};
         st_next.high   = value[15:8];
         st_next.status = st_reg.pair_act;
         st_next.irq_st = 1'b1;
      end
      // Samples since restart or last completion; only the length check reads it
      if (st_reg.reinit || !run_on) begin
         st_next.gap = 17'h0_0000;
      end else if (done) begin
         st_next.gap = 17'h0_0001;
      end else begin
         st_next.gap = st_reg.gap + 17'h0_0001;
      end
      if (wr_go) begin
         case (a)
            dsadc_pkg::CTL0_OFS: begin
               st_next.ctl0   = writedata[7:0] & 8'hF3;
               st_next.reinit = 1'b1;
            end
            dsadc_pkg::CTL1_OFS:    st_next.ctl1    = writedata[7:0] & 8'hE7;
            dsadc_pkg::PINSEL_OFS:  st_next.pinsel  = writedata[15:0];
            dsadc_pkg::PINDIR_OFS:  st_next.pindir  = writedata[7:0];
            dsadc_pkg::PORTOUT_OFS: st_next.portout = writedata[7:0];
            dsadc_pkg::IRQMSK_OFS:  st_next.irq_msk = writedata[0];
            // Set wins over a simultaneous write-one clear
            dsadc_pkg::IRQST_OFS:   st_next.irq_st  = (st_reg.irq_st & ~writedata[0]) | done;
            default: ;
         endcase
      end
      // Channel in use latched at restart so status reflects what finished
      if (st_reg.reinit) begin
         st_next.pair_act = st_reg.ctl0[dsadc_pkg::SELHI_BIT:dsadc_pkg::SELLO_BIT];
      end
      st_next.rdata = 32'h0000_0000;
      if (rd_go) begin
         case (a)
            dsadc_pkg::CTL0_OFS:    st_next.rdata = {24'h00_0000, st_reg.ctl0};
            dsadc_pkg::CTL1_OFS:    st_next.rdata = {24'h00_0000, st_reg.ctl1};
            dsadc_pkg::WIDE_OFS:    st_next.rdata = st_reg.wide;
            dsadc_pkg::HIGH_OFS:    st_next.rdata = {24'h00_0000, st_reg.high};
            dsadc_pkg::STAT_OFS:    st_next.rdata = {30'h0000_0000, st_reg.status};
            dsadc_pkg::PINSEL_OFS:  st_next.rdata = {16'h0000, st_reg.pinsel};
            dsadc_pkg::PINDIR_OFS:  st_next.rdata = {24'h00_0000, st_reg.pindir};
            dsadc_pkg::IRQST_OFS:   st_next.rdata = {31'h0000_0000, st_reg.irq_st};
            dsadc_pkg::IRQMSK_OFS:  st_next.rdata = {31'h0000_0000, st_reg.irq_msk};
            dsadc_pkg::PORTOUT_OFS: st_next.rdata = {24'h00_0000, st_reg.portout};
            dsadc_pkg::PORTIN_OFS:  st_next.rdata = {24'h00_0000, st_reg.pins};
            default:                st_next.rdata = 32'h0000_0000;
         endcase
      end
      // Pins left digital behave as port pins; analog pins never driven
      for (int i = 0; i < 8; i++) begin
         st_next.oe[i] = (st_reg.pinsel[2*i +: 2] == dsadc_pkg::PIN_DIGITAL)
                         && !st_reg.pindir[i];
      end
      st_next.out = st_reg.portout;
      // Three-stage synchroniser, change accepted when stages two and three agree
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < 8; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.pins[i] = st_reg.s3[i];
         end
      end
      st_next.irq = st_next.irq_st && st_next.irq_msk;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg        <= '0;
         st_reg.ctl0   <= dsadc_pkg::CTL_RST;
         st_reg.ctl1   <= dsadc_pkg::CTL_RST;
         st_reg.pinsel <= {8{dsadc_pkg::PINSEL_RST[1:0]}};
         st_reg.pindir <= dsadc_pkg::PINDIR_RST;
         st_reg.wait_q <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Registered handshake: one wait cycle per transfer, two for result reads
   assign waitrequest   = st_reg.wait_q;
   assign readdata      = st_reg.rdata;
   assign conv_done_irq = st_reg.irq;
   assign core_power    = st_reg.ctl0[dsadc_pkg::PON_BIT];
   assign core_pair     = st_reg.pair_act;
   assign pin_out       = st_reg.out;
   assign pin_oe        = st_reg.oe;

   // Assertions
   result_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      done |=> st_reg.wide[31:16] == $past(value) && st_reg.wide[15:0] == 16'h0000)
      else $error("wide result not loaded");
   high_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      done |=> st_reg.high == $past(value[15:8]))
      else $error("high byte not loaded");
   irq_follow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      done && st_reg.irq_msk && !(write && !waitrequest) |=> conv_done_irq)
      else $error("interrupt missing after conversion");
   read_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      read && is_result(address[5:2]) && waitrequest && !st_reg.rd_wait |=> waitrequest)
      else $error("result read not stretched");
   stop_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !st_reg.ctl0[dsadc_pkg::RUN_BIT] ##1 !st_reg.ctl0[dsadc_pkg::RUN_BIT] |-> !done)
      else $error("conversion while stopped");
   reinit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      write && !waitrequest && address[5:2] == dsadc_pkg::CTL0_OFS |=> st_reg.reinit ##1 !done)
      else $error("control write did not restart");
   analog_pin_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      st_reg.pinsel[1:0] != dsadc_pkg::PIN_DIGITAL ##1 $stable(st_reg.pinsel) |-> !pin_oe[0])
      else $error("analog pin driven");
   dir_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      st_reg.pinsel[1:0] == dsadc_pkg::PIN_DIGITAL && !st_reg.pindir[0] |=> pin_oe[0])
      else $error("output pin not driven");
   status_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      done |=> st_reg.status == $past(st_reg.pair_act))
      else $error("status channel wrong");
   // Bus handshake
   early_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      write && waitrequest |=> !st_reg.reinit)
      else $error("control write landed before acceptance");
   cfg_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !(write && !waitrequest) |=> $stable(st_reg.ctl0) && $stable(st_reg.ctl1)
         && $stable(st_reg.pinsel) && $stable(st_reg.pindir))
      else $error("configuration changed without a write");
   plain_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      read && !is_result(address[5:2]) && waitrequest |=> !waitrequest)
      else $error("plain read not answered after one wait");
   result_ready_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      read && is_result(address[5:2]) && st_reg.rd_wait |=> !waitrequest)
      else $error("result read not answered after its wait");
   single_ack_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !waitrequest |=> waitrequest)
      else $error("acceptance lasted more than one cycle");
   data_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !waitrequest |=> readdata == 32'h0000_0000)
      else $error("read data outlived its cycle");
   idle_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !read && !write |=> waitrequest)
      else $error("acceptance without request");
   // Results, status and interrupt
   result_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !done |=> $stable(st_reg.wide) && $stable(st_reg.high))
      else $error("result changed without completion");
   stop_result_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !st_reg.ctl0[dsadc_pkg::RUN_BIT] ##1 !st_reg.ctl0[dsadc_pkg::RUN_BIT]
         |=> $stable(st_reg.wide))
      else $error("result changed while stopped");
   status_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !done |=> $stable(st_reg.status))
      else $error("status changed without completion");
   flag_source_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !st_reg.irq_st && !done |=> !st_reg.irq_st)
      else $error("completion flag set without completion");
   irq_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      write && !waitrequest && address[5:2] == dsadc_pkg::IRQST_OFS && writedata[0] && !done
         |=> !st_reg.irq_st)
      else $error("completion flag not cleared");
   irq_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      conv_done_irq && !(write && !waitrequest) |=> conv_done_irq)
      else $error("interrupt dropped without a write");
   mask_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !st_reg.irq_msk && !(write && !waitrequest) |=> !conv_done_irq)
      else $error("masked interrupt raised");
   done_gap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      done |=> !done)
      else $error("completions back to back");
   conv_length_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      done |-> st_reg.gap == samples_of(st_reg.ctl1[dsadc_pkg::NSEL_LSB +: 3]))
      else $error("conversion length wrong");
   pair_latch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      st_reg.reinit |=> core_pair == $past(st_reg.ctl0[dsadc_pkg::SELHI_BIT:dsadc_pkg::SELLO_BIT]))
      else $error("channel not latched at restart");
   pair_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !st_reg.reinit |=> $stable(core_pair))
      else $error("channel changed without restart");
   // Shared pins
   dir_in_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      st_reg.pindir[0] |=> !pin_oe[0])
      else $error("input pin driven");
   dir_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      write && !waitrequest && address[5:2] == dsadc_pkg::PINDIR_OFS
         |=> st_reg.pindir == $past(writedata[7:0]))
      else $error("direction write lost");
   out_follow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> pin_out == $past(st_reg.portout))
      else $error("port output not following its register");
   sync_agree_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      st_reg.s2[0] != st_reg.s3[0] |=> $stable(st_reg.pins[0]))
      else $error("pin level taken before stages agree");
endmodule
`default_nettype wire

// ==== dsadc_ctrl_tb.sv ====
// Self-checking bench for the delta-sigma converter control block
`default_nettype none
module dsadc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, sys_rst, read, write, waitrequest, mod_bit, core_power, conv_done_irq;
   logic [5:0]  address;
   logic [31:0] writedata, readdata, rdv;
   logic [1:0]  core_pair;
   logic [7:0]  pin_in, pin_out, pin_oe, ext_drive;
   int          errors = 0;
   int          total_checks = 0;
   int          ws;
   dsadc_ctrl i_dsadc_ctrl (.sys_clk, .sys_rst, .address, .read, .write, .writedata,
      .readdata, .waitrequest, .mod_bit, .core_power, .core_pair, .pin_in, .pin_out,
      .pin_oe, .conv_done_irq);
   dsadc_source i_dsadc_source (.sys_clk, .core_power, .core_pair, .mod_bit, .pin_out,
      .pin_oe, .ext_drive, .pin_in);
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // Request rises after an edge and holds until waitrequest is sampled low at a rising edge
   task automatic bus(logic we, logic [3:0] w, logic [31:0] d);
      @(posedge sys_clk);
      address <= {w, 2'b00};
      writedata <= d;
      write <= we;
      read <= ~we;
      ws = 0;
      @(posedge sys_clk);
      while (waitrequest !== 1'b0) begin
         ws++;
         @(posedge sys_clk);
      end
      rdv = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic wr(logic [3:0] w, logic [31:0] d);
      bus(1'b1, w, d);
   endtask
   task automatic rdc(string n, logic [3:0] w, logic [31:0] e);
      bus(1'b0, w, 32'h0000_0000);
      chk(n, rdv, e);
   endtask
   task automatic wait_irq(int lo, int hi);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (conv_done_irq !== 1'b1 && n < hi);
      chk("irq_delay", 32'(n >= lo && n < hi), 32'h0000_0001);
   endtask
   task automatic reset_check();
      rdc("ctrl0", dsadc_pkg::CTL0_OFS, 32'h0000_0000);
      rdc("ctrl1", dsadc_pkg::CTL1_OFS, 32'h0000_0000);
      rdc("pindir", dsadc_pkg::PINDIR_OFS, 32'h0000_00FF);
      rdc("pinsel", dsadc_pkg::PINSEL_OFS, 32'h0000_0000);
      rdc("irq_st", dsadc_pkg::IRQST_OFS, 32'h0000_0000);
      wr(4'hB, 32'hFFFF_FFFF);
      rdc("unmapped", 4'hB, 32'h0000_0000);
      chk("oe_rst", 32'(pin_oe), 32'h0000_0000);
   endtask
   // Power first, count and run later: one run per call, the other converter never started
   task automatic conv(logic [1:0] p, logic [2:0] c, int n, logic [15:0] v);
      int wws;
      int hws;
      wr(dsadc_pkg::CTL0_OFS, 32'h0000_0080);
      wr(dsadc_pkg::CTL1_OFS, 32'(c));
      repeat (13) @(posedge sys_clk);
      wr(dsadc_pkg::IRQST_OFS, 32'h0000_0001);
      wr(dsadc_pkg::CTL0_OFS, 32'h0000_00C0 | 32'(p));
      wait_irq(n, n + 12);
      chk("pair", 32'(core_pair), 32'(p));
      wr(dsadc_pkg::IRQST_OFS, 32'h0000_0001);
      wait_irq(n - 8, n + 8);
      rdc("wide", dsadc_pkg::WIDE_OFS, {v, 16'h0000});
      wws = ws;
      rdc("high", dsadc_pkg::HIGH_OFS, {24'h00_0000, v[15:8]});
      hws = ws;
      rdc("status", dsadc_pkg::STAT_OFS, 32'(p));
      // A result read waits exactly one cycle longer than an ordinary read
      chk("wide_wait", 32'(wws - ws), 32'h0000_0001);
      chk("high_wait", 32'(hws - ws), 32'h0000_0001);
   endtask
   task automatic restart_stop();
      wr(dsadc_pkg::IRQST_OFS, 32'h0000_0001);
      repeat (150) @(posedge sys_clk);
      wr(dsadc_pkg::CTL0_OFS, 32'h0000_00C0);
      wait_irq(256, 268);
      wr(dsadc_pkg::CTL0_OFS, 32'h0000_0080);
      wr(dsadc_pkg::IRQST_OFS, 32'h0000_0001);
      repeat (600) @(negedge sys_clk);
      chk("irq_idle", 32'(conv_done_irq), 32'h0000_0000);
      rdc("st_idle", dsadc_pkg::IRQST_OFS, 32'h0000_0000);
      rdc("wide_kept", dsadc_pkg::WIDE_OFS, 32'h8000_0000);
   endtask
   task automatic mask_check();
      wr(dsadc_pkg::IRQMSK_OFS, 32'h0000_0000);
      wr(dsadc_pkg::CTL0_OFS, 32'h0000_00C0);
      repeat (300) @(negedge sys_clk);
      chk("irq_masked", 32'(conv_done_irq), 32'h0000_0000);
      rdc("st_set", dsadc_pkg::IRQST_OFS, 32'h0000_0001);
      wr(dsadc_pkg::IRQMSK_OFS, 32'h0000_0001);
      repeat (2) @(negedge sys_clk);
      chk("irq_unmasked", 32'(conv_done_irq), 32'h0000_0001);
   endtask
   task automatic pins();
      @(posedge sys_clk);
      ext_drive <= 8'h3C;
      wr(dsadc_pkg::PINDIR_OFS, 32'h0000_000F);
      wr(dsadc_pkg::PORTOUT_OFS, 32'h0000_00A5);
      wr(dsadc_pkg::PINSEL_OFS, 32'h0000_0006);
      rdc("pinsel", dsadc_pkg::PINSEL_OFS, 32'h0000_0006);
      repeat (4) @(negedge sys_clk);
      chk("oe", 32'(pin_oe), 32'h0000_00F0);
      chk("out", 32'(pin_out & pin_oe), 32'h0000_00A0);
      rdc("port_in", dsadc_pkg::PORTIN_OFS, 32'h0000_00AC);
   endtask
   task automatic finish_test();
      $display("errors %0d of %0d checks", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge sys_clk);
      errors++;
      finish_test();
   end
   initial begin
      sys_rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 6'h00;
      writedata = 32'h0000_0000;
      ext_drive = 8'h00;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      reset_check();
      wr(dsadc_pkg::IRQMSK_OFS, 32'h0000_0001);
      conv(2'h0, 3'h1, 1024, 16'h8000);
      conv(2'h0, 3'h2, 2048, 16'h8000);
      conv(2'h1, 3'h0, 256, 16'h4000);
      conv(2'h2, 3'h0, 256, 16'hC000);
      conv(2'h0, 3'h0, 256, 16'h8000);
      restart_stop();
      mask_check();
      pins();
      finish_test();
   end
endmodule
`default_nettype wire

// ==== dsadc_modulator.sv ====
// First-order modulator accumulator producing one conversion value
`default_nettype none
module dsadc_modulator (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // Control
   input  wire logic        clear,
   input  wire logic        run,
   input  wire logic [2:0]  nsel,
   // Sample bit stream from analog core
   input  wire logic        bit_in,
   // Result
   output logic             done,
   output logic [15:0]      value
);
   typedef struct packed {
      logic [16:0] cnt;
      logic [16:0] ones;
      logic        done;
      logic [15:0] value;
   } mod_t;
   mod_t st_reg, st_next;

   function automatic logic [16:0] n_of(input logic [2:0] s);
      n_of = (s == 3'h0) ? dsadc_pkg::N_MIN : 17'(dsadc_pkg::N_BASE << (s - 3'h1));
   endfunction

   always_comb begin
      logic [16:0] n;
      logic [16:0] ones_n;
      n = n_of(nsel);
      ones_n = st_reg.ones + {16'h0000, bit_in};
      st_next = st_reg;
      st_next.done = 1'b0;
      if (clear || !run) begin
         st_next.cnt = 17'h0_0000;
         st_next.ones = 17'h0_0000;
      end else if (st_reg.cnt == n - 17'h0_0001) begin
         st_next.cnt = 17'h0_0000;
         st_next.ones = 17'h0_0000;
         st_next.done = 1'b1;
         // Scale count of ones to 16 bits, saturating at full scale
         st_next.value = (ones_n >= n) ? 16'hFFFF
                       : 16'(({ones_n, 16'h0000} / {16'h0000, n}));
      end else begin
         st_next.cnt = st_reg.cnt + 17'h0_0001;
         st_next.ones = ones_n;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign done  = st_reg.done;
   assign value = st_reg.value;
endmodule
`default_nettype wire

// ==== dsadc_pkg.sv ====
// Shared constants for the delta-sigma converter control block
`default_nettype none
package dsadc_pkg;
   // Register word addresses (byte address / 4)
   localparam logic [3:0] CTL0_OFS    = 4'h0;
   localparam logic [3:0] CTL1_OFS    = 4'h1;
   localparam logic [3:0] WIDE_OFS    = 4'h2;
   localparam logic [3:0] HIGH_OFS    = 4'h3;
   localparam logic [3:0] STAT_OFS    = 4'h4;
   localparam logic [3:0] PINSEL_OFS  = 4'h5;
   localparam logic [3:0] PINDIR_OFS  = 4'h6;
   localparam logic [3:0] IRQST_OFS   = 4'h7;
   localparam logic [3:0] IRQMSK_OFS  = 4'h8;
   localparam logic [3:0] PORTOUT_OFS = 4'h9;
   localparam logic [3:0] PORTIN_OFS  = 4'hA;
   // First control register fields
   localparam int PON_BIT  = 7;
   localparam int RUN_BIT  = 6;
   localparam int SELHI_BIT = 1;
   localparam int SELLO_BIT = 0;
   // Second control register sample-count field
   localparam int NSEL_LSB = 0;
   // Reset values
   localparam logic [7:0] CTL_RST    = 8'h00;
   localparam logic [7:0] PINSEL_RST = 8'h00;
   localparam logic [7:0] PINDIR_RST = 8'hFF;
   // Sample counts
   localparam logic [16:0] N_MIN  = 17'h0_0100;
   localparam logic [16:0] N_BASE = 17'h0_0400;
   // Pin analog selection codes (two bits per pin)
   localparam logic [1:0] PIN_DIGITAL = 2'h0;
   localparam logic [1:0] PIN_DS      = 2'h1;
   localparam logic [1:0] PIN_SAR     = 2'h2;
endpackage
`default_nettype wire

// ==== dsadc_source.sv ====
// Analog source pairs and shared pin levels seen from outside the converter
`default_nettype none
module dsadc_source (
   // Clock
   input  wire logic       sys_clk,
   // Analog core
   input  wire logic       core_power,
   input  wire logic [1:0] core_pair,
   output logic            mod_bit,
   // Shared pins
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext_drive,
   output logic [7:0]      pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] phase_reg = 2'h0;
   always_ff @(posedge sys_clk) phase_reg <= phase_reg + 2'h1;
   // Densities 1/2, 1/4, 3/4 are exact over any window of 256 samples, whatever the phase
   always_comb begin
      case (core_pair)
         2'h0: mod_bit = phase_reg[0];
         2'h1: mod_bit = (phase_reg == 2'h0);
         2'h2: mod_bit = (phase_reg != 2'h0);
         default: mod_bit = phase_reg[1];
      endcase
      // Powered-down core gives a stream that repeats 0, 1, 1, 0 every four cycles
      if (core_power !== 1'b1) mod_bit = phase_reg[0] ^ phase_reg[1];
   end
   // A driven pin reads back its own level, an undriven one the outside source
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule
`default_nettype wire
